// ==== hdl/irq_mux_regs.svh ====
// Address map, field layout, option codes and reset values of the interrupt source select block.
// Assumes a 32-bit APB with byte addresses; included by bare name wherever the constants are needed.
`ifndef IRQ_MUX_REGS_SVH
`define IRQ_MUX_REGS_SVH

// Register byte addresses.
`define IRQ_SEL_LINES_0_3_ADDR   32'h4000b0c0
`define IRQ_SEL_LINES_4_7_ADDR   32'h4000b0c4
`define IRQ_SEL_LINES_8_11_ADDR  32'h4000b0c8
`define IRQ_SEL_LINES_12_15_ADDR 32'h4000b0cc
`define IRQ_SEL_LINES_16_19_ADDR 32'h4000b0d0
`define IRQ_SEL_LINE_20_ADDR     32'h4000b0d4
`define IRQ_EVT_STATUS_ADDR      32'h4000b0d8
`define IRQ_EVT_MASK_ADDR        32'h4000b0dc
`define IRQ_MAP_WORDS            8

// Field layout inside a select word.
`define IRQ_LINES_PER_REG        4
`define IRQ_FIELD_STRIDE         8
`define IRQ_SEL_W                5
`define IRQ_NUM_LINES            32
`define IRQ_NUM_MUX              21

// Option codes; code zero keeps the line's default source.
`define OPT_DEFAULT              5'h00
`define OPT_UART0_RX             5'h01
`define OPT_UART0_TX             5'h02
`define OPT_UART1_RX             5'h03
`define OPT_UART1_TX             5'h04
`define OPT_SPI0_RX              5'h05
`define OPT_SPI0_TX              5'h06
`define OPT_SPI1_RX              5'h07
`define OPT_SPI1_TX              5'h08
`define OPT_I2C0_RX              5'h09
`define OPT_I2C0_TX              5'h0a
`define OPT_I2C1_RX              5'h0b
`define OPT_I2C1_TX              5'h0c
`define OPT_WDT0                 5'h0d
`define OPT_WDT1                 5'h0e
`define OPT_DUAL_TIMER           5'h0f
`define OPT_DMA_STATUS           5'h10
`define OPT_SECURITY             5'h11
`define OPT_QUAD_DECODER         5'h13
`define OPT_BROWNOUT             5'h18
// One bit per code that routes nothing (0x12, 0x14 to 0x17, 0x19 to 0x1f).
`define OPT_RESERVED_MASK        32'hfef40000

// Event status and mask layout.
`define STAT_W                   2
`define STAT_RSVD_BIT            0
`define STAT_REMAP_BIT           1

// Reset values.
`define SEL_RESET                5'h00
`define STAT_RESET               2'h0
`define MASK_RESET               2'h0

`endif

// ==== hdl/irq_mux_pkg.sv ====
// Types shared by the interrupt source select block and its line selector.
// Assumes the peripheral request levels arrive synchronous to the system bus clock.
package irq_mux_pkg;

    // Request levels of the peripherals that can be routed onto a remappable line.
    typedef struct packed {
        logic uart0_rx;
        logic uart0_tx;
        logic uart1_rx;
        logic uart1_tx;
        logic spi0_rx;
        logic spi0_tx;
        logic spi1_rx;
        logic spi1_tx;
        logic i2c0_rx;
        logic i2c0_tx;
        logic i2c1_rx;
        logic i2c1_tx;
        logic wdt0;
        logic wdt1;
        logic dual_timer;
        logic dma_status;
        logic security;
        logic quad_decoder;
        logic brownout_event;
    } irq_sources_t;

    // Events that this block reports on its own interrupt output.
    typedef struct packed {
        logic remap;
        logic rsvd_code;
    } irq_events_t;

endpackage

// ==== hdl/irq_line_selector.sv ====
// One remappable interrupt line: picks the default source or one entry of the option vector.
// Assumes the option vector already holds zero at every reserved code.
`timescale 1ns/100ps
`include "irq_mux_regs.svh"

module irq_line_selector
    import irq_mux_pkg::*;
#(
    parameter int SEL_W = `IRQ_SEL_W
) (
    input  wire logic [SEL_W-1:0]      sel_i,
    input  wire logic                  default_i,
    input  wire logic [(1<<SEL_W)-1:0] opt_i,
    output logic                       req_o
);

    // Code zero is the default path; every other code indexes the shared option vector.
    always_comb begin
        if (sel_i == SEL_W'(`OPT_DEFAULT)) begin
            req_o = default_i;
        end else begin
            req_o = opt_i[sel_i];
        end
    end

endmodule

// ==== hdl/muxable_irq_source_select.sv ====
// Interrupt source select block: a bank of APB select registers that route peripheral
// requests onto the remappable request lines of the nested_vector_irq_ctrl.
// Assumes an APB4 master on clk_i and peripheral request levels synchronous to clk_i.
`timescale 1ns/100ps
`include "irq_mux_regs.svh"

//Function
// - Drive 32 request lines, each by default from its own fixed peripheral.
// - Only lines 0 to 20 are remappable; higher lines stay on their default.
// - Select value zero routes the default source; all selects reset to zero.
// - Each select register serves four consecutive lines; the last serves line 20.
// - Fields sit at bits 4:0, 12:8, 20:16, 28:24, lowest line lowest; rest unused.
// - One common option list; codes 0x16, 0x17 reserved, 0x18 selects brownout event.
// - Code 0x13 routes the quadrature decoder request onto the selected line.
// - Sources without a default line, like memory access status, can be selected.
module muxable_irq_source_select
    import irq_mux_pkg::*;
#(
    parameter int NUM_LINES = `IRQ_NUM_LINES,
    parameter int NUM_MUX   = `IRQ_NUM_MUX,
    parameter int SEL_W     = `IRQ_SEL_W
) (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [31:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    input  wire logic [3:0]           pstrb_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire logic [NUM_LINES-1:0] default_irq_i,
    input  wire irq_sources_t         sources_i,
    output logic      [NUM_LINES-1:0] irq_o,
    output logic                      event_irq_o
);

    // The address decode and field packing only serve the documented geometry.
    if (NUM_LINES != `IRQ_NUM_LINES || NUM_MUX < 1 || NUM_MUX > NUM_LINES ||
        SEL_W != `IRQ_SEL_W ||
        NUM_MUX > (`IRQ_MAP_WORDS - 2) * `IRQ_LINES_PER_REG) begin : g_param_check
        $error("muxable_irq_source_select: unsupported parameter set");
    end

    localparam int OPT_N = 1 << SEL_W;

    // A macro literal cannot be bit-selected, so the reserved-code map gets a named copy.
    localparam logic [31:0] RSVD_CODES = `OPT_RESERVED_MASK;

    // Word indices of the two event registers and of the last select register, derived from their byte addresses.
    localparam logic [2:0] STATUS_IDX = 3'((`IRQ_EVT_STATUS_ADDR - `IRQ_SEL_LINES_0_3_ADDR) >> 2);
    localparam logic [2:0] MASK_IDX   = 3'((`IRQ_EVT_MASK_ADDR - `IRQ_SEL_LINES_0_3_ADDR) >> 2);
    localparam logic [2:0] LAST_IDX   = 3'((`IRQ_SEL_LINE_20_ADDR - `IRQ_SEL_LINES_0_3_ADDR) >> 2);

    // Register state.
    logic [SEL_W-1:0]  sel_r [NUM_MUX];
    logic [`STAT_W-1:0] status_r;
    logic [`STAT_W-1:0] status_nxt;
    logic [`STAT_W-1:0] mask_r;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [NUM_LINES-1:0] irq_r;
    logic              event_irq_r;

    // Decode and datapath nets.
    logic [31:0]       addr_off;
    logic [2:0]        word_idx;
    logic              addr_hit;
    logic              setup_ph;
    logic              access_ph;
    logic              wr_acc;
    logic              rd_acc;
    logic [31:0]       rd_word;
    logic [OPT_N-1:0]  opt_vec;
    logic [NUM_LINES-1:0] routed;
    logic [NUM_MUX-1:0] wr_line;
    logic [NUM_MUX-1:0] wr_rsvd;
    logic [NUM_MUX-1:0] wr_change;
    irq_events_t       evt_set;

    // Address decode: one aligned word per register, anything else in or out of the map is an error.
    assign addr_off  = paddr_i - `IRQ_SEL_LINES_0_3_ADDR;
    assign word_idx  = addr_off[4:2];
    assign addr_hit  = (paddr_i[1:0] == 2'h0) && (addr_off < 32'(`IRQ_MAP_WORDS * 4));
    assign setup_ph  = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i && pready_r;
    assign wr_acc    = access_ph && pwrite_i && addr_hit;
    assign rd_acc    = access_ph && !pwrite_i && addr_hit;

    // Read word: select fields in their byte lanes, unused bits and absent lines read zero.
    always_comb begin
        int line;
        line    = 0;
        rd_word = 32'h0;
        if (word_idx <= LAST_IDX) begin
            for (int k = 0; k < `IRQ_LINES_PER_REG; k++) begin
                line = int'(word_idx) * `IRQ_LINES_PER_REG + k;
                if (line < NUM_MUX) begin
                    rd_word[k*`IRQ_FIELD_STRIDE +: SEL_W] = sel_r[line];
                end
            end
        end else if (word_idx == STATUS_IDX) begin
            rd_word[`STAT_W-1:0] = status_r;
        end else if (word_idx == MASK_IDX) begin
            rd_word[`STAT_W-1:0] = mask_r;
        end
    end

    // APB answer is prepared in the setup cycle, so every transfer completes with no wait state.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph && !addr_hit;
            if (setup_ph && !pwrite_i && addr_hit) begin
                prdata_r <= rd_word;
            end else if (setup_ph) begin
                prdata_r <= 32'h0;
            end
        end
    end

    // Option vector shared by every remappable line; unlisted codes stay zero so they route nothing.
    always_comb begin
        opt_vec                    = '0;
        opt_vec[`OPT_UART0_RX]     = sources_i.uart0_rx;
        opt_vec[`OPT_UART0_TX]     = sources_i.uart0_tx;
        opt_vec[`OPT_UART1_RX]     = sources_i.uart1_rx;
        opt_vec[`OPT_UART1_TX]     = sources_i.uart1_tx;
        opt_vec[`OPT_SPI0_RX]      = sources_i.spi0_rx;
        opt_vec[`OPT_SPI0_TX]      = sources_i.spi0_tx;
        opt_vec[`OPT_SPI1_RX]      = sources_i.spi1_rx;
        opt_vec[`OPT_SPI1_TX]      = sources_i.spi1_tx;
        opt_vec[`OPT_I2C0_RX]      = sources_i.i2c0_rx;
        opt_vec[`OPT_I2C0_TX]      = sources_i.i2c0_tx;
        opt_vec[`OPT_I2C1_RX]      = sources_i.i2c1_rx;
        opt_vec[`OPT_I2C1_TX]      = sources_i.i2c1_tx;
        opt_vec[`OPT_WDT0]         = sources_i.wdt0;
        opt_vec[`OPT_WDT1]         = sources_i.wdt1;
        opt_vec[`OPT_DUAL_TIMER]   = sources_i.dual_timer;
        opt_vec[`OPT_DMA_STATUS]   = sources_i.dma_status;
        opt_vec[`OPT_SECURITY]     = sources_i.security;
        opt_vec[`OPT_QUAD_DECODER] = sources_i.quad_decoder;
        opt_vec[`OPT_BROWNOUT]     = sources_i.brownout_event;
    end

    // Per-line select storage, write decode and routing.
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        if (g < NUM_MUX) begin : g_mux
            localparam logic [2:0] REG_IDX = 3'(g / `IRQ_LINES_PER_REG);
            localparam int         LANE    = g % `IRQ_LINES_PER_REG;
            logic [SEL_W-1:0] wr_val;

            assign wr_val         = pwdata_i[LANE*`IRQ_FIELD_STRIDE +: SEL_W];
            assign wr_line[g]     = wr_acc && (word_idx == REG_IDX) && pstrb_i[LANE];
            assign wr_rsvd[g]     = wr_line[g] && RSVD_CODES[wr_val];
            assign wr_change[g]   = wr_line[g] && (wr_val != sel_r[g]);

            // Only the byte lane that holds the field updates it; bits 7:5 of each lane are dropped.
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sel_r[g] <= `SEL_RESET;
                end else if (wr_line[g]) begin
                    sel_r[g] <= wr_val;
                end
            end

            irq_line_selector #(
                .SEL_W     (SEL_W)
            ) u_sel (
                .sel_i     (sel_r[g]),
                .default_i (default_irq_i[g]),
                .opt_i     (opt_vec),
                .req_o     (routed[g])
            );
        end else begin : g_fixed
            // Lines beyond the remappable range have no select and pass their default straight on.
            assign routed[g] = default_irq_i[g];
        end
    end

    // Request lines are registered once, so a new select reaches them at the edge after the write.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_r <= '0;
        end else begin
            irq_r <= routed;
        end
    end

    // Events of this block: a write of a code that routes nothing, and a select that changed value.
    assign evt_set.rsvd_code = |wr_rsvd;
    assign evt_set.remap     = |wr_change;

    // A read clears only the bits it returned, and a new event in the same cycle still sets its bit.
    always_comb begin
        status_nxt = status_r;
        if (rd_acc && word_idx == STATUS_IDX) begin
            status_nxt = status_nxt & ~prdata_r[`STAT_W-1:0];
        end
        status_nxt[`STAT_RSVD_BIT]  = status_nxt[`STAT_RSVD_BIT] | evt_set.rsvd_code;
        status_nxt[`STAT_REMAP_BIT] = status_nxt[`STAT_REMAP_BIT] | evt_set.remap;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_r <= `STAT_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Mask register; writes to the status word are ignored because it is cleared by reading.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mask_r <= `MASK_RESET;
        end else if (wr_acc && word_idx == MASK_IDX && pstrb_i[0]) begin
            mask_r <= pwdata_i[`STAT_W-1:0];
        end
    end

    // Event interrupt follows the next status value so it drops in the same edge as the clear.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            event_irq_r <= 1'b0;
        end else begin
            event_irq_r <= |(status_nxt & mask_r);
        end
    end

    // All outputs come straight from flip-flops.
    assign prdata_o    = prdata_r;
    assign pready_o    = pready_r;
    assign pslverr_o   = pslverr_r;
    assign irq_o       = irq_r;
    assign event_irq_o = event_irq_r;

    // Software is expected to program a line's select before enabling it downstream; the
    // routing itself is never gated, so a premature enable can see a stray request.

endmodule

// ==== test/irq_select_properties.sv ====
// Concurrent checks on the interrupt source select block, seeing only its top-level ports.
// Assumes it is bound into that module; line 0 and the event mask are shadowed here.
`timescale 1ns/100ps
`include "irq_mux_regs.svh"
module irq_select_properties
    import irq_mux_pkg::*;
#(
    parameter int NUM_LINES = 32
) (
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire logic                 psel_i,
    input wire logic                 penable_i,
    input wire logic                 pwrite_i,
    input wire logic [31:0]          paddr_i,
    input wire logic [31:0]          pwdata_i,
    input wire logic [3:0]           pstrb_i,
    input wire logic [31:0]          prdata_o,
    input wire logic                 pready_o,
    input wire logic                 pslverr_o,
    input wire logic [NUM_LINES-1:0] default_irq_i,
    input wire irq_sources_t         sources_i,
    input wire logic [NUM_LINES-1:0] irq_o,
    input wire logic                 event_irq_o
);
    localparam logic [31:0] RSVD = `OPT_RESERVED_MASK;
    logic [4:0] s0_r;
    logic [1:0] m_r;
    logic       wr;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // A write lands only at the access edge that also sees ready.
    assign wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
    // Shadows of line 0's select and of the mask, so routing can be predicted without the bodies.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s0_r <= 5'h00;
            m_r  <= 2'h0;
        end else if (wr && paddr_i == `IRQ_SEL_LINES_0_3_ADDR) begin
            s0_r <= pwdata_i[4:0];
        end else if (wr && paddr_i == `IRQ_EVT_MASK_ADDR) begin
            m_r <= pwdata_i[1:0];
        end
    end
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_bad_setup;
        s_setup ##0 (paddr_i < `IRQ_SEL_LINES_0_3_ADDR || paddr_i > `IRQ_EVT_MASK_ADDR);
    endsequence
    a_high_lines_fixed: assert property (
        $past(rstn_i) |-> irq_o[NUM_LINES-1:21] == $past(default_irq_i[NUM_LINES-1:21]))
        else $error("Lines above 20 left their default source.");
    a_zero_default: assert property (s0_r == 5'h00 |=> irq_o[0] == $past(default_irq_i[0]))
        else $error("Select zero did not route the default source.");
    a_quad_route: assert property (s0_r == 5'h13 |=> irq_o[0] == $past(sources_i.quad_decoder))
        else $error("Code 0x13 did not route the quadrature decoder.");
    a_brownout_route: assert property (s0_r == 5'h18 |=> irq_o[0] == $past(sources_i.brownout_event))
        else $error("Code 0x18 did not route the brownout event.");
    a_dma_route: assert property (s0_r == 5'h10 |=> irq_o[0] == $past(sources_i.dma_status))
        else $error("Code 0x10 did not route the memory access status.");
    a_rsvd_silent: assert property (RSVD[s0_r] |=> !irq_o[0])
        else $error("A reserved code routed a request.");
    a_answer_next: assert property (s_setup |=> pready_o)
        else $error("No answer in the first access cycle.");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("Ready stood longer than one cycle.");
    a_unmapped_err: assert property (s_bad_setup |=> pready_o && pslverr_o)
        else $error("An unmapped address was not refused.");
    a_rsvd_event: assert property (
        wr && paddr_i == `IRQ_SEL_LINES_0_3_ADDR && RSVD[pwdata_i[4:0]] && m_r[0] |=> event_irq_o)
        else $error("A reserved code write raised no event.");
endmodule

// ==== test/nested_vector_irq_ctrl_model.sv ====
// Behavioural model of the processor's interrupt controller fed by the routed request lines.
// Assumes request levels synchronous to clk_i; the bench sets the line enables.
`timescale 1ns/100ps
module nested_vector_irq_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [31:0] irq_i,
    input  wire logic [31:0] enable_i,
    output logic      [31:0] pending_o
);
    // Pending is latched only on enabled lines, so a line enabled before its select is set catches stale requests.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending_o <= 32'h00000000;
        end else begin
            pending_o <= pending_o | (irq_i & enable_i);
        end
    end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the interrupt source select block with an interrupt controller model.
// Assumes the header, package and design are compiled first; one 50 MHz clock.
`timescale 1ns/100ps
`include "irq_mux_regs.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import irq_mux_pkg::*;
    localparam logic [31:0] RSVD = `OPT_RESERVED_MASK;
    logic         clk_i, rstn_i, psel, penable, pwrite, pready, pslverr, evt, er;
    logic [31:0]  paddr, pwdata, prdata, dflt, irq, pend, en, rd;
    irq_sources_t src;
    int           failures, samples_checked, cycles = 0;
    muxable_irq_source_select dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .default_irq_i(dflt), .sources_i(src), .irq_o(irq),
        .event_irq_o(evt));
    nested_vector_irq_ctrl_model ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .irq_i(irq), .enable_i(en), .pending_o(pend));
    // Free-running system clock.
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Cut a hang short; the whole run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One APB transfer; the request is held until ready is sampled high.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Only the bench timeout ends this wait; the slave decides how long it takes.
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Routed lines are registered, so two edges cover the field update and the input change.
    task automatic settle();
        repeat (2) @(posedge clk_i);
    endtask
    task automatic t_reset();
        dflt <= 32'ha5c30f96;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, `IRQ_SEL_LINES_0_3_ADDR + 32'(4 * i), 32'h0);
            `CHK("select reset", 32'h0, rd)
        end
        settle();
        `CHK("default lines", 32'ha5c30f96, irq)
    endtask
    task automatic t_layout();
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `IRQ_SEL_LINES_0_3_ADDR + 32'(4 * i), 32'hffffffff);
            apb(1'b0, `IRQ_SEL_LINES_0_3_ADDR + 32'(4 * i), 32'h0);
            `CHK("field layout", (i == 5) ? 32'h0000001f : 32'h1f1f1f1f, rd)
        end
        src <= irq_sources_t'(19'h7ffff);
        settle();
        `CHK("reserved everywhere", 32'ha5c00000, irq)
    endtask
    // Every code on line 0: first all sources high, then only the expected source low.
    task automatic t_codes();
        int b;
        for (int c = 0; c < 32; c++) begin
            b = (c == 19) ? 1 : (c == 24) ? 0 : 19 - c;
            apb(1'b1, `IRQ_SEL_LINES_0_3_ADDR, 32'(c));
            src <= irq_sources_t'(19'h7ffff);
            dflt <= 32'h0;
            settle();
            `CHK("code routes", (c != 0 && !RSVD[c]), irq[0])
            src <= irq_sources_t'(~(19'h1 << b));
            dflt <= 32'hffffffff;
            settle();
            `CHK("code picks source", c == 0, irq[0])
        end
    endtask
    task automatic t_example();
        dflt <= 32'h0;
        src <= irq_sources_t'(19'h2);
        apb(1'b1, `IRQ_SEL_LINES_8_11_ADDR, 32'h13000000);
        en[11] <= 1'b1; // Enabled only once the select is in place.
        settle();
        @(posedge clk_i);
        `CHK("line 11 routed", 4'h8, irq[11:8])
        `CHK("controller pending", 32'h800, pend)
    endtask
    task automatic t_events();
        apb(1'b1, `IRQ_EVT_MASK_ADDR, 32'h3);
        apb(1'b0, `IRQ_EVT_STATUS_ADDR, 32'h0);
        @(posedge clk_i);
        `CHK("event idle", 1'b0, evt)
        apb(1'b1, `IRQ_SEL_LINES_0_3_ADDR, 32'h16);
        @(posedge clk_i);
        `CHK("event raised", 1'b1, evt)
        apb(1'b0, `IRQ_EVT_STATUS_ADDR, 32'h0);
        `CHK("event status", 32'h3, rd)
        @(posedge clk_i);
        `CHK("event cleared", 1'b0, evt)
        apb(1'b1, `IRQ_EVT_MASK_ADDR, 32'h0);
        apb(1'b1, `IRQ_SEL_LINES_0_3_ADDR, 32'h17);
        @(posedge clk_i);
        `CHK("event masked", 1'b0, evt)
    endtask
    task automatic t_edges();
        apb(1'b0, 32'h4000b0e0, 32'h0);
        `CHK("unmapped error", 33'h100000000, {er, rd})
        src <= irq_sources_t'(19'h1);
        dflt <= 32'h0;
        apb(1'b1, `IRQ_SEL_LINE_20_ADDR, 32'h18);
        settle();
        `CHK("line 20 brownout", 2'b01, irq[21:20])
    endtask
    // Reset, then the scenarios in order.
    initial begin
        {rstn_i, psel, penable, pwrite, paddr, pwdata, dflt, en, src} = '0;
        failures = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_layout();
        t_codes();
        t_example();
        t_events();
        t_edges();
        close_out();
    end
endmodule
bind muxable_irq_source_select irq_select_properties #(.NUM_LINES(NUM_LINES)) props (.clk_i(clk_i),
    .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .default_irq_i(default_irq_i), .sources_i(sources_i), .irq_o(irq_o), .event_irq_o(event_irq_o));
